// *** src/hps_regs.vh ***
`ifndef HPS_REGS_VH
`define HPS_REGS_VH

// system clock rate and internal timebase
`define HPS_CLK_MHZ 100
`define HPS_TICK_US 1
`define HPS_TICK_CYC (`HPS_CLK_MHZ * `HPS_TICK_US)
`define HPS_TICK_W 7

// timer width in ticks, wide enough for the power-hold window
`define HPS_TMR_W 19

// sequencing times in microseconds, as printed
`define HPS_KEY_DB_US 32000
`define HPS_CHG_DB_US 32000
`define HPS_SEQ_SHORT_US 125
`define HPS_SEQ_LONG_US 10000
`define HPS_RST_DLY_US 20000
`define HPS_HOLD_MAX_US 500000
`define HPS_PD_DLY_US 20000

// the same times as counts of timebase ticks
`define HPS_KEY_DB_TICKS (`HPS_KEY_DB_US / `HPS_TICK_US)
`define HPS_CHG_DB_TICKS (`HPS_CHG_DB_US / `HPS_TICK_US)
`define HPS_SEQ_SHORT_TICKS (`HPS_SEQ_SHORT_US / `HPS_TICK_US)
`define HPS_SEQ_LONG_TICKS (`HPS_SEQ_LONG_US / `HPS_TICK_US)
`define HPS_RST_DLY_TICKS (`HPS_RST_DLY_US / `HPS_TICK_US)
`define HPS_HOLD_MAX_TICKS (`HPS_HOLD_MAX_US / `HPS_TICK_US)
`define HPS_PD_DLY_TICKS (`HPS_PD_DLY_US / `HPS_TICK_US)

// idle levels of the debounced pins
`define HPS_KEY_IDLE 1'b0
`define HPS_CHG_IDLE 1'b1

`endif

// *** src/hps_tick.v ***
`timescale 1ns/100ps
`include "hps_regs.vh"

module hps_tick #(
    parameter [`HPS_TICK_W-1:0] TICK_CYC = `HPS_TICK_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // timebase
    output reg tick_r
);

reg [`HPS_TICK_W-1:0] div_r;

// free-running divider, one pulse per timebase period
always @(posedge sys_clk) begin
    if (reset) begin
        div_r <= {`HPS_TICK_W{1'b0}};
        tick_r <= 1'b0;
    end else if (clk_en) begin
        if (div_r == TICK_CYC - 1'b1) begin
            div_r <= {`HPS_TICK_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end
end

endmodule

// *** src/hps_debounce.v ***
`timescale 1ns/100ps
`include "hps_regs.vh"

module hps_debounce #(
    parameter [`HPS_TMR_W-1:0] DB_TICKS = `HPS_KEY_DB_TICKS,
    parameter IDLE = 1'b0
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // timebase and raw pin
    input wire tick,
    input wire pin_raw,
    // filtered level
    output reg level_r
);

reg meta_r;
reg sync_r;
reg [`HPS_TMR_W-1:0] cnt_r;

// two-stage synchroniser; only sync_r is looked at
always @(posedge sys_clk) begin
    if (reset) begin
        meta_r <= IDLE;
        sync_r <= IDLE;
    end else if (clk_en) begin
        meta_r <= pin_raw;
        sync_r <= meta_r;
    end
end

// the new level must hold for the full window; any bounce restarts it
always @(posedge sys_clk) begin
    if (reset) begin
        cnt_r <= {`HPS_TMR_W{1'b0}};
        level_r <= IDLE;
    end else if (clk_en) begin
        if (sync_r == level_r) begin
            cnt_r <= {`HPS_TMR_W{1'b0}};
        end else if (tick) begin
            if (cnt_r >= DB_TICKS - 1'b1) begin
                level_r <= sync_r;
                cnt_r <= {`HPS_TMR_W{1'b0}};
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
end

endmodule

// *** src/hps_sequencer.v ***
`timescale 1ns/100ps
`include "hps_regs.vh"

// Contract
// - key wake input is debounced for 32 ms before a press counts
// - valid key press asserts wake interrupt and enables the primary regulator
// - primary good, then 125 us or 10 ms, then secondary enabled
// - both regulators good starts 20 ms timer, then host reset released
// - power-hold timer starts at reset release, allows at most 500 ms
// - power-hold rising in time clears interrupt and stays powered
// - power-hold low past 500 ms clears interrupt, resets host, powers down
// - host drops power-hold to request shutdown; device then resets host
// - secondary regulator disabled 20 ms after host reset goes low
// - secondary below 90 percent, then 125 us or 10 ms, primary disabled
// - a key press while powered does not itself power down
// - either regulator below 90 percent drives host reset low at once
// - charger detect is active low and debounced 32 ms
// - charger while powered is flagged, outputs otherwise unchanged
// - charger while off enables primary after 32 ms, normal power-up
// - charger power-up keeps wake interrupt deasserted throughout
// - while charger is attached both regulators stay on despite power-hold low
// - charger removed while power-hold low resets host and powers down
// - with charger attached, power down only if charger gone and hold low; the code also powers down on a regulator fault
// - power-good flags set at upper threshold, clear at lower threshold
module hps_sequencer #(
    parameter [`HPS_TMR_W-1:0] KEY_DB_TICKS = `HPS_KEY_DB_TICKS,
    parameter [`HPS_TMR_W-1:0] CHG_DB_TICKS = `HPS_CHG_DB_TICKS,
    parameter [`HPS_TMR_W-1:0] SEQ_SHORT_TICKS = `HPS_SEQ_SHORT_TICKS,
    parameter [`HPS_TMR_W-1:0] SEQ_LONG_TICKS = `HPS_SEQ_LONG_TICKS,
    parameter [`HPS_TMR_W-1:0] RST_DLY_TICKS = `HPS_RST_DLY_TICKS,
    parameter [`HPS_TMR_W-1:0] HOLD_MAX_TICKS = `HPS_HOLD_MAX_TICKS,
    parameter [`HPS_TMR_W-1:0] PD_DLY_TICKS = `HPS_PD_DLY_TICKS,
    parameter [`HPS_TICK_W-1:0] TICK_CYC = `HPS_TICK_CYC
) (
    // clock, reset, enable
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // wake sources and host handshake pins
    input wire key_wake_input,
    input wire charger_detect_n,
    input wire host_power_hold,
    input wire long_delay_sel,
    // regulator comparators
    input wire pri_above_hi,
    input wire pri_below_lo,
    input wire sec_above_hi,
    input wire sec_below_lo,
    // regulator enables and host reset
    output reg primary_regulator_en,
    output reg secondary_regulator_en,
    output reg host_reset_n,
    // open-drain wake interrupt
    output wire wake_irq_n_out,
    output wire wake_irq_n_oe,
    // charger status
    output reg charger_attached,
    output reg charger_event
);

// one-hot sequencer states
localparam [6:0] ST_OFF = 7'h01;
localparam [6:0] ST_PRI = 7'h02;
localparam [6:0] ST_SEC = 7'h04;
localparam [6:0] ST_RST = 7'h08;
localparam [6:0] ST_HOLD = 7'h10;
localparam [6:0] ST_ON = 7'h20;
localparam [6:0] ST_PD = 7'h40;

// power-down phases
localparam [1:0] PD_WAIT_RST = 2'h0;
localparam [1:0] PD_WAIT_SEC = 2'h1;
localparam [1:0] PD_WAIT_PRI = 2'h2;

wire tick;
wire key_level;
wire chg_level_n;

reg [5:0] meta_r;
reg [5:0] sync_r;
reg pri_good_r;
reg sec_good_r;
reg key_d_r;
reg irq_r;
reg [6:0] state_r;
reg [6:0] state_nxt;
reg [1:0] phase_r;
reg [1:0] phase_nxt;
reg [`HPS_TMR_W-1:0] timer_r;
reg [`HPS_TMR_W-1:0] timer_nxt;
reg pri_nxt;
reg sec_nxt;
reg rst_n_nxt;
reg irq_nxt;
reg go_pd;

// timebase for every delay in the block
hps_tick #(
    .TICK_CYC(TICK_CYC)
) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick_r(tick)
);

// key filter
hps_debounce #(
    .DB_TICKS(KEY_DB_TICKS),
    .IDLE(`HPS_KEY_IDLE)
) u_key_db (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(tick),
    .pin_raw(key_wake_input),
    .level_r(key_level)
);

// charger filter, kept active low
hps_debounce #(
    .DB_TICKS(CHG_DB_TICKS),
    .IDLE(`HPS_CHG_IDLE)
) u_chg_db (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(tick),
    .pin_raw(charger_detect_n),
    .level_r(chg_level_n)
);

// two-flop synchroniser for comparators, hold and delay select
always @(posedge sys_clk) begin
    if (reset) begin
        meta_r <= 6'h00;
        sync_r <= 6'h00;
    end else if (clk_en) begin
        meta_r <= {long_delay_sel, host_power_hold, sec_below_lo, sec_above_hi,
                   pri_below_lo, pri_above_hi};
        sync_r <= meta_r;
    end
end

wire pri_hi_s = sync_r[0];
wire pri_lo_s = sync_r[1];
wire sec_hi_s = sync_r[2];
wire sec_lo_s = sync_r[3];
wire hold_s = sync_r[4];
wire long_s = sync_r[5];

// hysteretic power-good flags; upper crossing wins if both are seen
always @(posedge sys_clk) begin
    if (reset) begin
        pri_good_r <= 1'b0;
        sec_good_r <= 1'b0;
    end else if (clk_en) begin
        if (pri_hi_s) begin
            pri_good_r <= 1'b1;
        end else if (pri_lo_s) begin
            pri_good_r <= 1'b0;
        end
        if (sec_hi_s) begin
            sec_good_r <= 1'b1;
        end else if (sec_lo_s) begin
            sec_good_r <= 1'b0;
        end
    end
end

wire key_press = key_level & ~key_d_r;
wire chg_att = ~chg_level_n;
wire reg_fault = ~pri_good_r | ~sec_good_r;
wire timer_done = (timer_r == {`HPS_TMR_W{1'b0}});
// the variant select is sampled live; changing it mid-sequence is not supported
wire [`HPS_TMR_W-1:0] seq_ticks = long_s ? SEQ_LONG_TICKS : SEQ_SHORT_TICKS;

// sequencer next state
always @* begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    timer_nxt = timer_r;
    pri_nxt = primary_regulator_en;
    sec_nxt = secondary_regulator_en;
    rst_n_nxt = host_reset_n;
    irq_nxt = irq_r;
    go_pd = 1'b0;
    if (tick && !timer_done) begin
        timer_nxt = timer_r - 1'b1;
    end
    case (state_r)
        ST_OFF: begin
            pri_nxt = 1'b0;
            sec_nxt = 1'b0;
            rst_n_nxt = 1'b0;
            irq_nxt = 1'b0;
            timer_nxt = seq_ticks;
            if (key_press) begin
                irq_nxt = 1'b1;
                pri_nxt = 1'b1;
                state_nxt = ST_PRI;
            end else if (chg_att) begin
                // charger start leaves the interrupt released
                pri_nxt = 1'b1;
                state_nxt = ST_PRI;
            end
        end
        ST_PRI: begin
            // delay restarts until the primary is good
            if (!pri_good_r) begin
                timer_nxt = seq_ticks;
            end else if (timer_done) begin
                sec_nxt = 1'b1;
                state_nxt = ST_SEC;
            end
        end
        ST_SEC: begin
            if (pri_good_r && sec_good_r) begin
                timer_nxt = RST_DLY_TICKS;
                state_nxt = ST_RST;
            end
        end
        ST_RST: begin
            if (reg_fault) begin
                go_pd = 1'b1;
            end else if (timer_done) begin
                rst_n_nxt = 1'b1;
                timer_nxt = HOLD_MAX_TICKS;
                state_nxt = ST_HOLD;
            end
        end
        ST_HOLD: begin
            if (reg_fault) begin
                go_pd = 1'b1;
            end else if (hold_s) begin
                irq_nxt = 1'b0;
                state_nxt = ST_ON;
            end else if (timer_done) begin
                irq_nxt = 1'b0;
                if (chg_att) begin
                    state_nxt = ST_ON;
                end else begin
                    go_pd = 1'b1;
                end
            end
        end
        ST_ON: begin
            // key presses are ignored here
            if (reg_fault) begin
                go_pd = 1'b1;
            end else if (!hold_s && !chg_att) begin
                go_pd = 1'b1;
            end
        end
        ST_PD: begin
            rst_n_nxt = 1'b0;
            irq_nxt = 1'b0;
            case (phase_r)
                PD_WAIT_RST: begin
                    if (timer_done) begin
                        sec_nxt = 1'b0;
                        phase_nxt = PD_WAIT_SEC;
                    end
                end
                PD_WAIT_SEC: begin
                    timer_nxt = seq_ticks;
                    if (!sec_good_r) begin
                        phase_nxt = PD_WAIT_PRI;
                    end
                end
                PD_WAIT_PRI: begin
                    if (timer_done) begin
                        pri_nxt = 1'b0;
                        state_nxt = ST_OFF;
                        phase_nxt = PD_WAIT_RST;
                    end
                end
                default: begin
                    phase_nxt = PD_WAIT_RST;
                end
            endcase
        end
        default: begin
            state_nxt = ST_OFF;
            pri_nxt = 1'b0;
            sec_nxt = 1'b0;
            rst_n_nxt = 1'b0;
            irq_nxt = 1'b0;
        end
    endcase
    // common entry into power-down: reset first, regulators follow
    if (go_pd) begin
        rst_n_nxt = 1'b0;
        irq_nxt = 1'b0;
        timer_nxt = PD_DLY_TICKS;
        phase_nxt = PD_WAIT_RST;
        state_nxt = ST_PD;
    end
end

// sequencer registers, off after reset
always @(posedge sys_clk) begin
    if (reset) begin
        state_r <= ST_OFF;
        phase_r <= PD_WAIT_RST;
        timer_r <= {`HPS_TMR_W{1'b0}};
        primary_regulator_en <= 1'b0;
        secondary_regulator_en <= 1'b0;
        host_reset_n <= 1'b0;
        irq_r <= 1'b0;
    end else if (clk_en) begin
        state_r <= state_nxt;
        phase_r <= phase_nxt;
        timer_r <= timer_nxt;
        primary_regulator_en <= pri_nxt;
        secondary_regulator_en <= sec_nxt;
        host_reset_n <= rst_n_nxt;
        irq_r <= irq_nxt;
    end
end

// key edge and charger status; a charger while powered is only flagged
always @(posedge sys_clk) begin
    if (reset) begin
        key_d_r <= `HPS_KEY_IDLE;
        charger_attached <= 1'b0;
        charger_event <= 1'b0;
    end else if (clk_en) begin
        key_d_r <= key_level;
        charger_attached <= chg_att;
        charger_event <= chg_att & ~charger_attached & ~state_r[0];
    end
end

// pin is only ever pulled low; the board supplies the high level
assign wake_irq_n_out = 1'b0;
assign wake_irq_n_oe = irq_r;

endmodule

// *** test/hps_host_model.sv ***
`timescale 1ns/100ps
// far side of the sequencer: host processor plus the two regulators' comparators
module hps_host_model (
    // clock
    input wire sys_clk,
    // host handshake
    input wire host_reset_n,
    input wire hold_ok,
    output wire host_power_hold,
    // regulators
    input wire pri_en,
    input wire sec_en,
    input wire pri_fault,
    output wire pri_above_hi,
    output wire pri_below_lo,
    output wire sec_above_hi,
    output wire sec_below_lo
);
    reg [2:0] hold_d = 3'h0;
    reg [2:0] pri_d = 3'h0;
    reg [2:0] sec_d = 3'h0;

    // host boots three cycles after reset release and drops hold three cycles after reset falls
    always @(posedge sys_clk) begin
        hold_d <= {hold_d[1:0], host_reset_n & hold_ok};
        pri_d <= {pri_d[1:0], pri_en};
        sec_d <= {sec_d[1:0], sec_en};
    end

    // comparators: ramp lags the enable; a fault forces the output out of range
    assign host_power_hold = hold_d[2];
    assign pri_above_hi = pri_d[2] & ~pri_fault;
    assign pri_below_lo = ~pri_above_hi;
    assign sec_above_hi = sec_d[2];
    assign sec_below_lo = ~sec_d[2];
endmodule

// *** test/hps_seq_chk.sv ***
`timescale 1ns/100ps
// windows allow one tick of timebase jitter plus input synchroniser delay
module hps_seq_chk #(
    parameter [18:0] SEQ_SHORT_TICKS = 19'h2,
    parameter [18:0] RST_DLY_TICKS = 19'h6,
    parameter [18:0] PD_DLY_TICKS = 19'h6,
    parameter [6:0] TICK_CYC = 7'h4
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // pins in
    input wire host_power_hold,
    input wire pri_above_hi,
    input wire pri_below_lo,
    input wire sec_above_hi,
    input wire sec_below_lo,
    // pins out
    input wire primary_regulator_en,
    input wire secondary_regulator_en,
    input wire host_reset_n,
    input wire wake_irq_n_oe,
    input wire charger_attached
);
    localparam int SQ_MIN = (SEQ_SHORT_TICKS - 1) * TICK_CYC;
    localparam int RS_MIN = (RST_DLY_TICKS - 1) * TICK_CYC;
    localparam int PD_MIN = (PD_DLY_TICKS - 1) * TICK_CYC - 2;
    localparam int PD_MAX = (PD_DLY_TICKS + 1) * TICK_CYC + 4;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_reset_off;
        disable iff (1'b0) reset |=> !primary_regulator_en && !secondary_regulator_en
            && !host_reset_n && !wake_irq_n_oe;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("outputs not cleared by reset");

    property p_irq_key;
        $rose(wake_irq_n_oe) |-> $rose(primary_regulator_en) && !charger_attached;
    endproperty
    a_irq_key: assert property (p_irq_key) else $error("wake irq without key power-up");

    property p_sec_gap;
        $rose(secondary_regulator_en) |-> primary_regulator_en && $past(pri_above_hi, SQ_MIN);
    endproperty
    a_sec_gap: assert property (p_sec_gap) else $error("secondary enabled too early");

    property p_rst_delay;
        $rose(host_reset_n) |-> pri_above_hi && $past(sec_above_hi, RS_MIN);
    endproperty
    a_rst_delay: assert property (p_rst_delay) else $error("host reset released early");

    property p_hold_ack;
        $rose(host_power_hold) && wake_irq_n_oe && host_reset_n
            |-> ##[1:6] !wake_irq_n_oe && host_reset_n;
    endproperty
    a_hold_ack: assert property (p_hold_ack) else $error("hold did not clear wake irq");

    property p_hold_drop;
        $fell(host_power_hold) && host_reset_n && !charger_attached |-> ##[1:6] !host_reset_n;
    endproperty
    a_hold_drop: assert property (p_hold_drop) else $error("hold drop left reset high");

    property p_fault;
        $rose(pri_below_lo || sec_below_lo) && host_reset_n |-> ##[1:6] !host_reset_n;
    endproperty
    a_fault: assert property (p_fault) else $error("regulator fault left reset high");

    property p_pd_sec;
        $fell(host_reset_n) && !$past(reset) |-> ##[PD_MIN:PD_MAX] $fell(secondary_regulator_en);
    endproperty
    a_pd_sec: assert property (p_pd_sec) else $error("secondary off at wrong time");

    property p_pd_pri;
        $fell(primary_regulator_en) && !$past(reset)
            |-> !secondary_regulator_en && $past(sec_below_lo, SQ_MIN);
    endproperty
    a_pd_pri: assert property (p_pd_pri) else $error("primary off at wrong time");

    // main scenarios
    c_key_up: cover property ($rose(host_reset_n) && wake_irq_n_oe);
    c_chg_up: cover property ($rose(host_reset_n) && charger_attached);
    c_timeout: cover property ($fell(host_reset_n) && wake_irq_n_oe);
endmodule

// *** test/handset_power_sequencer_tb_top.sv ***
`timescale 1ns/100ps
module handset_power_sequencer_tb_top;
    reg sys_clk = 1'b0;
    reg reset = 1'b1;
    reg key = 1'b0;
    reg chg_n = 1'b1;
    reg lds = 1'b0;
    reg hold_ok = 1'b0;
    reg fault = 1'b0;
    reg ev_seen = 1'b0;
    reg [3:0] last = 4'h0;
    reg [3:0] exp_q[$];
    wire pri, sec, rst_n, irq_out, irq_oe, attached, event_p, hold;
    wire pah, pbl, sah, sbl;
    integer num_errors = 0;
    integer checks_done = 0;
    integer seed = 32'h2125;
    integer i;
    // open-drain wake line with the board pull-up
    wire wake_line = irq_oe ? irq_out : 1'b1;

    always #5 sys_clk = ~sys_clk;

    hps_sequencer #(.KEY_DB_TICKS(19'h4), .CHG_DB_TICKS(19'h4), .SEQ_SHORT_TICKS(19'h2),
        .SEQ_LONG_TICKS(19'h5), .RST_DLY_TICKS(19'h6), .HOLD_MAX_TICKS(19'h14),
        .PD_DLY_TICKS(19'h6), .TICK_CYC(7'h4)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .key_wake_input(key),
        .charger_detect_n(chg_n), .host_power_hold(hold), .long_delay_sel(lds),
        .pri_above_hi(pah), .pri_below_lo(pbl), .sec_above_hi(sah), .sec_below_lo(sbl),
        .primary_regulator_en(pri), .secondary_regulator_en(sec), .host_reset_n(rst_n),
        .wake_irq_n_out(irq_out), .wake_irq_n_oe(irq_oe), .charger_attached(attached),
        .charger_event(event_p));

    hps_host_model host_u (.sys_clk(sys_clk), .host_reset_n(rst_n), .hold_ok(hold_ok),
        .host_power_hold(hold), .pri_en(pri), .sec_en(sec), .pri_fault(fault),
        .pri_above_hi(pah), .pri_below_lo(pbl), .sec_above_hi(sah), .sec_below_lo(sbl));

    task check(input [3:0] seen, input [3:0] want);
        begin
            checks_done = checks_done + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask

    // note the output steps {pri, sec, reset, irq} expected next, oldest first
    task put(input [15:0] s, input integer n);
        for (i = n - 1; i >= 0; i = i - 1)
            exp_q.push_back(s[4*i +: 4]);
    endtask

    // bounded wait for every noted step to show up, then a quiet spell
    task drain(input integer t);
        begin
            i = 0;
            while (exp_q.size() != 0 && i < 2000) begin
                @(negedge sys_clk);
                i = i + 1;
            end
            check(exp_q.size(), 4'h0);
            exp_q.delete();
            repeat (120) @(negedge sys_clk);
            $display("test %0d done", t);
        end
    endtask

    // short random bounces first; only the long press may count
    task press;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                key = 1'b1;
                repeat ({$random(seed)} % 8 + 1) @(negedge sys_clk);
                key = 1'b0;
                repeat (20) @(negedge sys_clk);
            end
            key = 1'b1;
            repeat (40) @(negedge sys_clk);
            key = 1'b0;
        end
    endtask

    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // every change of the output set is matched against the oldest note
    always @(negedge sys_clk) begin
        if (event_p === 1'b1)
            ev_seen <= 1'b1;
        if (!reset && {pri, sec, rst_n, ~wake_line} !== last) begin
            last = {pri, sec, rst_n, ~wake_line};
            check(last, exp_q.size() != 0 ? exp_q.pop_front() : 4'hx);
        end
    end

    initial begin
        #700000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        // key start, host holds, charger while on, then host shutdown
        hold_ok = 1'b1;
        put(16'h9dfe, 4);
        press;
        drain(1);
        press;
        chg_n = 1'b0;
        repeat (60) @(negedge sys_clk);
        check({2'h0, attached, ev_seen}, 4'h3);
        chg_n = 1'b1;
        repeat (60) @(negedge sys_clk);
        hold_ok = 1'b0;
        put(16'h0c80, 3);
        drain(2);
        // long regulator gap, host never answers
        lds = 1'b1;
        put(16'h9dfc, 4);
        press;
        put(16'h0080, 2);
        drain(3);
        // regulator fault while on
        lds = 1'b0;
        hold_ok = 1'b1;
        put(16'h9dfe, 4);
        press;
        drain(4);
        fault = 1'b1;
        put(16'h0c80, 3);
        drain(5);
        fault = 1'b0;
        // charger start, hold timeout and key ignored, removal shuts down
        hold_ok = 1'b0;
        put(16'h08ce, 3);
        chg_n = 1'b0;
        drain(6);
        press;
        put(16'h0c80, 3);
        chg_n = 1'b1;
        drain(7);
        tally_and_finish;
    end
endmodule

bind hps_sequencer hps_seq_chk #(.SEQ_SHORT_TICKS(SEQ_SHORT_TICKS),
    .RST_DLY_TICKS(RST_DLY_TICKS), .PD_DLY_TICKS(PD_DLY_TICKS), .TICK_CYC(TICK_CYC)) chk_u (
    .sys_clk(sys_clk), .reset(reset), .host_power_hold(host_power_hold),
    .pri_above_hi(pri_above_hi), .pri_below_lo(pri_below_lo), .sec_above_hi(sec_above_hi),
    .sec_below_lo(sec_below_lo), .primary_regulator_en(primary_regulator_en),
    .secondary_regulator_en(secondary_regulator_en), .host_reset_n(host_reset_n),
    .wake_irq_n_oe(wake_irq_n_oe), .charger_attached(charger_attached));
